// ---- mqf_pkg.sv ----
`default_nettype none
package mqf_pkg;
	// ************************************************************
	// sizes and timing
	// ************************************************************
	localparam int QN = 32;
	localparam int QW = 5;
	localparam int PW = 4;
	localparam int CW = 5;
	localparam logic [CW-1:0] FULL_LEVEL = 5'h10;
	localparam logic [CW-1:0] AF_LEVEL_RST = 5'h0e;
	localparam logic [QW-1:0] SMALL_CFG_MAX = 5'h07;
	localparam logic FM_POLLED = 1'b1;
	// ************************************************************
	// apb register map
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_AF_LEVEL = 8'h04;
	localparam logic [7:0] REG_FULL_MAP = 8'h08;
	localparam logic [7:0] REG_AF_MAP = 8'h0c;
	localparam logic [7:0] REG_MARKS = 8'h10;
	localparam logic [7:0] REG_QUEUES = 8'h14;
	localparam int CTRL_PKT_BIT = 0;
	localparam int CTRL_NQ_LSB = 8;
	localparam logic [QW-1:0] NQ_CFG_RST = 5'h1f;
	localparam logic CTRL_PKT_RST = 1'b0;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_QS0 = 2'b01,
		SW_QS1 = 2'b10,
		SW_QS2 = 2'b11
	} mqf_sw_t;
	typedef struct packed {
		logic en_n;
		logic sel_en;
		logic [QW-1:0] addr;
		logic sop;
		logic eop;
	} mqf_wr_t;
	typedef struct packed {
		logic en_n;
		logic sel_en;
		logic [QW-1:0] addr;
	} mqf_rd_t;
	typedef struct packed {
		logic valid;
		logic [QW-1:0] q;
		logic [PW-1:0] loc;
	} mqf_mark_t;
endpackage : mqf_pkg
`default_nettype wire

// ---- mqf_core.sv ----
// Summary of operation
// - marks are placed or removed only inside a queue switch sequence
// - packet mode keeps one marked location per port
// - packet mode lets writes resume from the marked location
// - write mark moves after end marker then a further valid write
// - read mark hops start-to-start as valid reads pass
// - plain mode write mark sits at queue start and never moves
// - plain mode read mark only at queue start, never moves
// - switch with select enable low in QS0 clears the mark, same queue or another
// - one marked queue per port; new mark replaces old
// - enable sampled at switch keeps or drops the existing mark
// - eight-bit almost-full bus reports eight queues at a time
// - nine or more queues share bus, direct or polled per reset strap
// - eight or fewer queues each own a dedicated bus bit
// - full state kept per queue; flag shows write-selected queue only
// - full flag shows new queue by fourth edge; writes allowed then
// - full flag changes only on rising clock edges
// - unselected queue full state still follows reads
// - select enable in QS0 marks the next queue, low means no mark
// - write switch with write idle returns a marked present queue to its mark, else leaves its pointer alone
// - read switch with read idle returns a marked present queue to its read mark, else leaves its read pointer alone
// - read switch takes four cycles, present queue readable only if read enabled at QS-1
`timescale 1ns/10ps
`default_nettype none
module mqf_core (
	input wire logic i_clk, // 100 MHz clock
	input wire logic i_rst_n, // sync reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error on unmapped
	input wire mqf_pkg::mqf_wr_t i_wr, // write port controls
	input wire mqf_pkg::mqf_rd_t i_rd, // read port controls
	input wire logic i_flag_bus_mode_sel, // flag bus mode strap
	output logic o_active_queue_full_n, // active write queue full
	output logic o_active_almost_full_n, // active write queue almost full
	output logic [7:0] o_almost_full_status_bus, // almost-full group, low active
	output logic [1:0] o_af_bus_group, // group shown on status bus
	output logic o_wr_accept, // write taken last cycle
	output logic o_rd_accept, // read taken last cycle
	output mqf_pkg::mqf_mark_t o_wr_mark, // write port mark
	output mqf_pkg::mqf_mark_t o_rd_mark // read port mark
);
	import mqf_pkg::*;
	function automatic logic [CW-1:0] mqf_back(input logic [PW-1:0] ptr, input logic [PW-1:0] loc);
		mqf_back = {1'b0, ptr - loc};
	endfunction : mqf_back

	// ************************************************************
	// apb slave
	// ************************************************************
	logic pkt_mode;
	logic [QW-1:0] nq_cfg;
	logic [CW-1:0] af_level;
	logic fm_mode;
	logic [QN-1:0] full;
	logic [QN-1:0] af;
	logic [QN-1:0] empty;
	mqf_sw_t wsw;
	mqf_sw_t rsw;
	logic [QW-1:0] wcur;
	logic [QW-1:0] wnq;
	logic [QW-1:0] rcur;
	logic [QW-1:0] rnq;
	logic wkeep;
	logic rkeep;
	mqf_mark_t wmark;
	mqf_mark_t rmark;
	logic setup;
	logic apb_wr;
	logic mapped;
	logic [31:0] next_prdata;

	assign setup = i_psel && !i_penable;
	assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;

	always_comb begin
		mapped = 1'b1;
		next_prdata = 32'h0;
		case (i_paddr)
			REG_CTRL: next_prdata = {19'h0, nq_cfg, 7'h0, pkt_mode};
			REG_AF_LEVEL: next_prdata = {27'h0, af_level};
			REG_FULL_MAP: next_prdata = full;
			REG_AF_MAP: next_prdata = af;
			REG_MARKS: next_prdata = {12'h0, rmark, wmark};
			REG_QUEUES: next_prdata = {16'h0, rsw, 1'b0, rcur, wsw, 1'b0, wcur};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= setup;
			o_prdata <= setup ? next_prdata : 32'h0;
			o_pslverr <= setup && !mapped;
		end
	end

	// strap is caught while reset is held, then frozen
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pkt_mode <= CTRL_PKT_RST;
			nq_cfg <= NQ_CFG_RST;
			af_level <= AF_LEVEL_RST;
			fm_mode <= i_flag_bus_mode_sel;
		end else if (apb_wr && i_paddr == REG_CTRL) begin
			pkt_mode <= i_pwdata[CTRL_PKT_BIT];
			nq_cfg <= i_pwdata[CTRL_NQ_LSB +: QW];
		end else if (apb_wr && i_paddr == REG_AF_LEVEL) begin
			af_level <= i_pwdata[CW-1:0];
		end
	end

	// ************************************************************
	// queue switch sequencers
	// ************************************************************
	logic wsel_now;
	logic rsel_now;
	logic wr_do;
	logic rd_do;
	logic wrewind;
	logic rrewind;

	assign wsel_now = (wsw == SW_IDLE) && i_wr.sel_en;
	assign rsel_now = (rsw == SW_IDLE) && i_rd.sel_en;
	// during QS0-QS2 the present queue moves only if enabled at QS-1
	assign wr_do = !i_wr.en_n && !full[wcur] && (wsw == SW_IDLE || wkeep);
	assign rd_do = !i_rd.en_n && !empty[rcur] && (rsw == SW_IDLE || rkeep);
	// idle enable at QS-1 returns the present queue to its mark
	assign wrewind = wsel_now && i_wr.en_n && wmark.valid && wmark.q == wcur;
	assign rrewind = rsel_now && i_rd.en_n && rmark.valid && rmark.q == rcur;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wsw <= SW_IDLE;
			wcur <= '0;
			wnq <= '0;
			wkeep <= 1'b0;
		end else begin
			case (wsw)
				SW_IDLE: begin
					if (i_wr.sel_en) begin
						wsw <= SW_QS0;
						wnq <= i_wr.addr;
						wkeep <= !i_wr.en_n;
					end
				end
				SW_QS0: wsw <= SW_QS1;
				SW_QS1: wsw <= SW_QS2;
				SW_QS2: begin
					wsw <= SW_IDLE;
					wcur <= wnq;
				end
				default: wsw <= SW_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rsw <= SW_IDLE;
			rcur <= '0;
			rnq <= '0;
			rkeep <= 1'b0;
		end else begin
			case (rsw)
				SW_IDLE: begin
					if (i_rd.sel_en) begin
						rsw <= SW_QS0;
						rnq <= i_rd.addr;
						rkeep <= !i_rd.en_n;
					end
				end
				SW_QS0: rsw <= SW_QS1;
				SW_QS1: rsw <= SW_QS2;
				SW_QS2: begin
					rsw <= SW_IDLE;
					rcur <= rnq;
				end
				default: rsw <= SW_IDLE;
			endcase
		end
	end

	// ************************************************************
	// per-queue pointers and occupancy
	// ************************************************************
	logic [CW-1:0] cnt [QN];
	logic [PW-1:0] wptr [QN];
	logic [PW-1:0] rptr [QN];
	logic [QN-1:0] sop_mem [1 << PW];

	for (genvar gq = 0; gq < QN; gq++) begin : g_q
		localparam logic [QW-1:0] QID = QW'(gq);
		logic wh;
		logic rh;
		logic wb;
		logic rb;
		assign wh = wr_do && wcur == QID;
		assign rh = rd_do && rcur == QID;
		assign wb = wrewind && wcur == QID;
		assign rb = rrewind && rcur == QID;
		always_ff @(posedge i_clk) begin
			if (!i_rst_n) begin
				cnt[gq] <= '0;
				wptr[gq] <= '0;
				rptr[gq] <= '0;
			end else begin
				if (wb)
					wptr[gq] <= wmark.loc;
				else if (wh)
					wptr[gq] <= wptr[gq] + 4'h1;
				if (rb)
					rptr[gq] <= rmark.loc;
				else if (rh)
					rptr[gq] <= rptr[gq] + 4'h1;
				// reads drain any queue, selected for writing or not
				cnt[gq] <= cnt[gq] + {4'h0, wh} - {4'h0, rh}
					- (wb ? mqf_back(wptr[gq], wmark.loc) : 5'h0)
					+ (rb ? mqf_back(rptr[gq], rmark.loc) : 5'h0);
			end
		end
		assign full[gq] = cnt[gq] == FULL_LEVEL;
		assign empty[gq] = cnt[gq] == 5'h0;
		assign af[gq] = cnt[gq] >= af_level;
	end

	always_ff @(posedge i_clk) begin
		if (wr_do)
			sop_mem[wptr[wcur]][wcur] <= i_wr.sop;
	end

	// ************************************************************
	// marks
	// ************************************************************
	logic weop_pend;
	logic [PW-1:0] rnext;
	assign rnext = rptr[rcur] + 4'h1;

	// limitation: a rewrite after reads passed the mark is not guarded
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wmark <= '0;
			weop_pend <= 1'b0;
		end else if (wsw == SW_QS0) begin
			// one mark per port; select enable here decides it
			wmark.valid <= i_wr.sel_en;
			wmark.q <= wnq;
			wmark.loc <= pkt_mode ? wptr[wnq] : rptr[wnq];
			weop_pend <= 1'b0;
		end else if (wsel_now && !i_wr.en_n) begin
			wmark.valid <= 1'b0;
		end else if (pkt_mode && wmark.valid && wr_do && wcur == wmark.q) begin
			if (weop_pend)
				wmark.loc <= wptr[wcur];
			weop_pend <= i_wr.eop;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rmark <= '0;
		end else if (rsw == SW_QS0) begin
			rmark.valid <= i_rd.sel_en;
			rmark.q <= rnq;
			rmark.loc <= rptr[rnq];
		end else if (rsel_now && !i_rd.en_n) begin
			rmark.valid <= 1'b0;
		end else if (pkt_mode && rmark.valid && rd_do && rcur == rmark.q
			&& sop_mem[rnext][rcur]) begin
			rmark.loc <= rnext;
		end
	end

	// ************************************************************
	// flags and status outputs
	// ************************************************************
	logic [QW-1:0] fq;
	logic [1:0] grp;
	logic [1:0] poll;
	assign fq = (wsw == SW_QS2) ? wnq : wcur;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_active_queue_full_n <= 1'b1;
			o_active_almost_full_n <= 1'b1;
		end else begin
			o_active_queue_full_n <= !full[fq];
			o_active_almost_full_n <= !af[fq];
		end
	end

	always_comb begin
		if (nq_cfg <= SMALL_CFG_MAX)
			grp = 2'h0;
		else if (fm_mode == FM_POLLED)
			grp = poll;
		else
			grp = wcur[QW-1:QW-2];
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			poll <= 2'h0;
			o_almost_full_status_bus <= 8'hff;
			o_af_bus_group <= 2'h0;
		end else begin
			poll <= (poll == nq_cfg[QW-1:QW-2]) ? 2'h0 : poll + 2'h1;
			o_almost_full_status_bus <= ~af[{grp, 3'h0} +: 8];
			o_af_bus_group <= grp;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_wr_accept <= 1'b0;
			o_rd_accept <= 1'b0;
			o_wr_mark <= '0;
			o_rd_mark <= '0;
		end else begin
			o_wr_accept <= wr_do;
			o_rd_accept <= rd_do;
			o_wr_mark <= wmark;
			o_rd_mark <= rmark;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_full_switch_lat: assert property ((wsw == SW_QS2) |=>
		o_active_queue_full_n == !$past(full[wnq])) else $error("full flag late");
	a_rd_switch_len: assert property (rsel_now |=> (rsw == SW_QS0) ##1
		(rsw == SW_QS1) ##1 (rsw == SW_QS2) ##1 (rsw == SW_IDLE)) else $error("bad read switch");
	a_wmark_in_switch: assert property ($rose(wmark.valid) |->
		$past(wsw) == SW_QS0) else $error("mark outside switch");
	a_plain_wmark_fixed: assert property (!pkt_mode && $past(wmark.valid)
		&& $past(wsw) != SW_QS0 |-> $stable(wmark.loc)) else $error("plain mark moved");
	a_plain_rmark_fixed: assert property (!pkt_mode && $past(rmark.valid)
		&& $past(rsw) != SW_QS0 |-> $stable(rmark.loc)) else $error("plain read mark moved");
	a_wr_pq_hold: assert property ((wsw != SW_IDLE) && !wkeep |=>
		wptr[$past(wcur)] == $past(wptr[wcur])) else $error("write pointer moved in idle switch");
	a_rd_pq_hold: assert property ((rsw != SW_IDLE) && !rkeep |=>
		rptr[$past(rcur)] == $past(rptr[rcur])) else $error("read pointer moved in idle switch");
	a_small_bus_map: assert property (nq_cfg <= SMALL_CFG_MAX |=>
		o_af_bus_group == 2'h0) else $error("small config not dedicated");
	a_mark_from_qs0: assert property ((wsw == SW_QS0) |=>
		wmark.valid == $past(i_wr.sel_en)) else $error("qs0 mark mismatch");
	c_wr_switch_mark: cover property ((wsw == SW_QS0) && i_wr.sel_en);
	c_rewrite: cover property (wrewind);
	c_pkt_move: cover property (pkt_mode && $changed(rmark.loc) && rsw == SW_IDLE);
endmodule : mqf_core
`default_nettype wire

// ---- mqf_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mqf_ctrl_model (
	input wire logic i_clk, // port clock
	output var mqf_pkg::mqf_wr_t o_wr, // write port drive
	output var mqf_pkg::mqf_rd_t o_rd // read port drive
);
	import mqf_pkg::*;
	// ************************************************************
	// idle levels
	// ************************************************************
	initial begin
		o_wr = '{en_n: 1'b1, sel_en: 1'b0, addr: 5'h00, sop: 1'b0, eop: 1'b0};
		o_rd = '{en_n: 1'b1, sel_en: 1'b0, addr: 5'h00};
	end
	// ************************************************************
	// queue switch sequences
	// ************************************************************
	// returns after qs2; the next request lands one edge after the first legal edge
	task automatic wr_sel(input logic [QW-1:0] q, input logic mk);
		@(posedge i_clk);
		o_wr.sel_en <= 1'b1;
		o_wr.addr <= q;
		@(posedge i_clk);
		o_wr.sel_en <= mk;
		@(posedge i_clk);
		o_wr.sel_en <= 1'b0;
		o_wr.addr <= ~q; // stale address never equals the requested queue
		repeat (2) @(posedge i_clk);
	endtask : wr_sel
	task automatic rd_sel(input logic [QW-1:0] q, input logic mk);
		@(posedge i_clk);
		o_rd.sel_en <= 1'b1;
		o_rd.addr <= q;
		@(posedge i_clk);
		o_rd.sel_en <= mk;
		@(posedge i_clk);
		o_rd.sel_en <= 1'b0;
		o_rd.addr <= ~q;
		repeat (2) @(posedge i_clk);
	endtask : rd_sel
	// ************************************************************
	// data transfers
	// ************************************************************
	task automatic wr_words(input int n, input logic s, input logic e);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_wr.en_n <= 1'b0;
			o_wr.sop <= s && (i == 0);
			o_wr.eop <= e && (i == n - 1);
		end
		@(posedge i_clk);
		o_wr.en_n <= 1'b1;
		o_wr.sop <= 1'b0;
		o_wr.eop <= 1'b0;
	endtask : wr_words
	task automatic rd_words(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_rd.en_n <= 1'b0;
		end
		@(posedge i_clk);
		o_rd.en_n <= 1'b1;
	endtask : rd_words
endmodule : mqf_ctrl_model
`default_nettype wire

// ---- multiqueue_mark_and_full_flag_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module multiqueue_mark_and_full_flag_tb_top;
	import mqf_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, fm = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, full_n, af_n, wacc, racc;
	logic [7:0] afbus;
	logic [1:0] grp;
	mqf_wr_t wr;
	mqf_rd_t rdp;
	mqf_mark_t wmk, rmk;
	int bad_count = 0;
	int n_compared = 0;
	always #5 i_clk = ~i_clk;
	mqf_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_wr(wr), .i_rd(rdp),
		.i_flag_bus_mode_sel(fm), .o_active_queue_full_n(full_n),
		.o_active_almost_full_n(af_n), .o_almost_full_status_bus(afbus),
		.o_af_bus_group(grp), .o_wr_accept(wacc), .o_rd_accept(racc),
		.o_wr_mark(wmk), .o_rd_mark(rmk));
	mqf_ctrl_model ctl (.i_clk(i_clk), .o_wr(wr), .o_rd(rdp));
	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1) begin
			@(posedge i_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic rst(input logic strap);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		fm <= strap;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
	endtask : rst
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		bad_count++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		rst(FM_POLLED);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, {19'h0, NQ_CFG_RST, 7'h0, CTRL_PKT_RST});
		apb(1'b0, REG_AF_LEVEL, 32'h0);
		chk(rd, {27'h0, AF_LEVEL_RST});
		apb(1'b0, 8'h3c, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		$display("test regs done");
		ctl.wr_sel(5'h03, 1'b0);
		ctl.wr_words(FULL_LEVEL, 1'b0, 1'b0);
		tick(2);
		chk(full_n, 1'b0);
		chk(af_n, 1'b0);
		apb(1'b0, REG_FULL_MAP, 32'h0);
		chk(rd[3], 1'b1);
		tick(0);
		for (int i = 0; i < 8 && grp !== 2'h0; i++) tick(1);
		chk(afbus[3], 1'b0);
		tick(1);
		chk(grp, 2'h1);
		ctl.wr_sel(5'h04, 1'b0);
		tick(1);
		chk(full_n, 1'b1);
		chk(af_n, 1'b1);
		ctl.wr_sel(5'h03, 1'b0);
		tick(1);
		chk(full_n, 1'b0);
		ctl.wr_sel(5'h04, 1'b0);
		ctl.rd_sel(5'h03, 1'b1);
		tick(1);
		chk(rmk.valid, 1'b1);
		chk(rmk.q, 5'h03);
		ctl.rd_words(1);
		tick(0);
		chk(racc, 1'b1);
		tick(3);
		apb(1'b0, REG_FULL_MAP, 32'h0);
		chk(rd[3], 1'b0);
		chk(full_n, 1'b1);
		$display("test full flag done");
		ctl.wr_sel(5'h05, 1'b1);
		tick(1);
		chk(wmk, {1'b1, 5'h05, 4'h0});
		ctl.wr_words(2, 1'b0, 1'b0);
		tick(1);
		chk(wmk.loc, 4'h0);
		ctl.wr_sel(5'h06, 1'b1);
		tick(1);
		chk(wmk.q, 5'h06);
		ctl.wr_sel(5'h06, 1'b0);
		tick(1);
		chk(wmk.valid, 1'b0);
		$display("test plain marks done");
		apb(1'b1, REG_CTRL, {19'h0, NQ_CFG_RST, 7'h0, 1'b1});
		ctl.wr_sel(5'h09, 1'b1);
		ctl.wr_words(2, 1'b1, 1'b1);
		tick(1);
		chk(wmk.loc, 4'h0);
		ctl.wr_words(1, 1'b0, 1'b0);
		tick(0);
		chk(wacc, 1'b1);
		tick(1);
		chk(wmk, {1'b1, 5'h09, 4'h2});
		ctl.wr_sel(5'h07, 1'b1);
		ctl.wr_words(2, 1'b1, 1'b0);
		ctl.wr_sel(5'h08, 1'b0);
		ctl.wr_sel(5'h07, 1'b0);
		ctl.wr_words(FULL_LEVEL - 2, 1'b0, 1'b0);
		tick(2);
		chk(full_n, 1'b1);
		ctl.wr_words(2, 1'b0, 1'b0);
		tick(2);
		chk(full_n, 1'b0);
		ctl.wr_words(1, 1'b0, 1'b0);
		tick(0);
		chk(wacc, 1'b0);
		$display("test packet marks done");
		rst(~FM_POLLED);
		ctl.wr_sel(5'h09, 1'b0);
		tick(1);
		chk(grp, 2'h1);
		apb(1'b1, REG_CTRL, {19'h0, SMALL_CFG_MAX, 8'h0});
		tick(2);
		chk(grp, 2'h0);
		tick(1);
		chk(grp, 2'h0);
		$display("test flag bus done");
		end_sim();
	end
endmodule : multiqueue_mark_and_full_flag_tb_top
`default_nettype wire
